// *** core/handoff_map.svh ***
`ifndef HANDOFF_MAP_SVH
`define HANDOFF_MAP_SVH

// register byte offsets
`define HO_CTRL_OFF     12'h000
`define HO_CAP_OFF      12'h004
`define HO_STATUS_OFF   12'h008
`define HO_URCNT_OFF    12'h00c
`define HO_ADDR_W       12

// field positions
`define HO_CTRL_SWITCH  0
`define HO_CAP_REQ      0
`define HO_ST_READY     0
`define HO_ST_EOS       1
`define HO_ST_LINK      2
`define HO_ST_RESET     3
`define HO_ST_CREQ      4
`define HO_ST_CGNT      5
`define HO_ST_CREL      6
`define HO_ST_ACCESS    7
`define HO_ST_INIT      8

// widths and reset values
`define HO_CRIT_W       8
`define HO_CRIT_IDLE    8'h00
`define HO_TAG_W        8
`define HO_CNT_W        16
`define HO_CNT_RST      16'h0000

`endif

// *** core/handoff_pkg.sv ***
`default_nettype none
package handoff_pkg;

    typedef enum logic [1:0] {
        ST_WAIT_S1 = 2'b00,
        ST_STAGE1  = 2'b01,
        ST_LOAD_S2 = 2'b10,
        ST_RUN     = 2'b11
    } load_state_t;

    typedef logic [7:0] crit_t;
    typedef logic [7:0] tag_t;

endpackage
`default_nettype wire

// *** core/input_mask.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "handoff_map.svh"

module input_mask (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 sel_pass,
    input  wire handoff_pkg::crit_t   usr_in,
    output logic [`HO_CRIT_W-1:0]     core_in
);
    import handoff_pkg::*;

    logic [`HO_CRIT_W-1:0] mask_ff;
    logic [`HO_CRIT_W-1:0] nxt_mask;
    localparam logic [`HO_CRIT_W-1:0] IDLE = `HO_CRIT_IDLE;

    // ************************************************
    // per-bit input multiplexers
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < `HO_CRIT_W; i = i + 1) begin : g_bit
            always_comb begin
                nxt_mask[i] = sel_pass ? usr_in[i] : IDLE[i];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= `HO_CRIT_IDLE;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    assign core_in = mask_ff;

endmodule
`default_nettype wire

// *** core/ur_responder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "handoff_map.svh"

module ur_responder (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 stage2_ready,
    input  wire logic                 rx_valid,
    input  wire logic                 rx_hard,
    input  wire logic                 rx_bar_hit,
    input  wire handoff_pkg::tag_t    rx_tag,
    output logic                      ur_valid,
    output logic [`HO_TAG_W-1:0]      ur_tag,
    output logic                      fwd_valid,
    output logic [`HO_TAG_W-1:0]      fwd_tag
);
    import handoff_pkg::*;

    logic                 ur_v_ff;
    logic                 fwd_v_ff;
    logic [`HO_TAG_W-1:0] tag_ff;
    logic                 nxt_ur_v;
    logic                 nxt_fwd_v;
    logic [`HO_TAG_W-1:0] nxt_tag;

    always_comb begin
        nxt_ur_v  = 1'b0;
        nxt_fwd_v = 1'b0;
        nxt_tag   = tag_ff;
        if (rx_valid && !rx_hard) begin
            nxt_tag = rx_tag;
            if (!stage2_ready) begin
                nxt_ur_v = 1'b1;
            end else begin
                nxt_fwd_v = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ur_v_ff  <= 1'b0;
            fwd_v_ff <= 1'b0;
            tag_ff   <= '0;
        end else begin
            ur_v_ff  <= nxt_ur_v;
            fwd_v_ff <= nxt_fwd_v;
            tag_ff   <= nxt_tag;
        end
    end

    assign ur_valid  = ur_v_ff;
    assign fwd_valid = fwd_v_ff;
    assign ur_tag    = tag_ff;
    assign fwd_tag   = tag_ff;

endmodule
`default_nettype wire

// *** core/staged_config_handoff.sv ***
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "handoff_map.svh"

module staged_config_handoff (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`HO_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    eos_in,
    output logic                         eos_out,
    output logic                         stage2_ready,
    input  wire handoff_pkg::crit_t      usr_crit_in,
    output logic [`HO_CRIT_W-1:0]        core_crit_in,
    input  wire logic                    rx_valid,
    input  wire logic                    rx_hard,
    input  wire logic                    rx_bar_hit,
    input  wire handoff_pkg::tag_t       rx_tag,
    output logic                         ur_valid,
    output logic [`HO_TAG_W-1:0]         ur_tag,
    output logic                         fwd_valid,
    output logic [`HO_TAG_W-1:0]         fwd_tag,
    output logic                         cap_req,
    input  wire logic                    cap_gnt,
    input  wire logic                    cap_rel,
    output logic                         cfg_access,
    input  wire logic                    core_reset_in,
    input  wire logic                    link_up_in,
    output logic                         user_reset,
    output logic                         user_lnk_up
);
    import handoff_pkg::*;

    // ************************************************
    // state
    // ************************************************
    load_state_t             state_ff;
    load_state_t             nxt_state;
    logic                    ready_ff;
    logic                    nxt_ready;
    logic                    init_done_ff;
    logic                    nxt_init_done;
    logic                    eos_ff;
    logic                    sw_req_ff;
    logic                    nxt_sw_req;
    logic                    cap_req_ff;
    logic                    nxt_cap_req;
    logic                    access_ff;
    logic                    nxt_access;
    logic                    reset_ff;
    logic                    link_ff;
    logic [`HO_CNT_W-1:0]    urcnt_ff;
    logic [`HO_CNT_W-1:0]    nxt_urcnt;
    logic [31:0]             rdata_ff;
    logic [31:0]             nxt_rdata;
    logic                    err_ff;
    logic                    nxt_err;
    logic                    setup;
    logic                    wr_acc;
    logic                    hit;
    logic                    ur_pulse;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    // ************************************************
    // stage tracking from end-of-startup
    // ************************************************
    always_comb begin
        nxt_state     = state_ff;
        nxt_ready     = ready_ff;
        nxt_init_done = init_done_ff;
        unique case (state_ff)
            ST_WAIT_S1: begin
                if (eos_in) begin
                    nxt_state = ST_STAGE1;
                end
            end
            ST_STAGE1: begin
                if (!eos_in) begin
                    nxt_state = ST_LOAD_S2;
                end
            end
            ST_LOAD_S2: begin
                if (eos_in) begin
                    nxt_state     = ST_RUN;
                    nxt_ready     = 1'b1;
                    nxt_init_done = 1'b1;
                end
            end
            ST_RUN: begin
                if (wr_acc && paddr == `HO_CTRL_OFF) begin
                    nxt_ready = pwdata[`HO_CTRL_SWITCH];
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= ST_WAIT_S1;
            ready_ff     <= 1'b0;
            init_done_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            ready_ff     <= nxt_ready;
            init_done_ff <= nxt_init_done;
        end
    end

    // ************************************************
    // pass-through and core status
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eos_ff   <= 1'b0;
            reset_ff <= 1'b1;
            link_ff  <= 1'b0;
        end else begin
            eos_ff   <= eos_in;
            reset_ff <= core_reset_in;
            link_ff  <= link_up_in && !core_reset_in;
        end
    end

    // ************************************************
    // configuration port arbitration
    // ************************************************
    always_comb begin
        nxt_sw_req = sw_req_ff;
        if (cap_rel) begin
            nxt_sw_req = 1'b0;
        end
        if (wr_acc && paddr == `HO_CAP_OFF) begin
            nxt_sw_req = pwdata[`HO_CAP_REQ];
        end
        nxt_cap_req = nxt_sw_req;
        nxt_access  = cap_req_ff && cap_gnt && !cap_rel;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_req_ff  <= 1'b0;
            cap_req_ff <= 1'b0;
            access_ff  <= 1'b0;
        end else begin
            sw_req_ff  <= nxt_sw_req;
            cap_req_ff <= nxt_cap_req;
            access_ff  <= nxt_access;
        end
    end

    // ************************************************
    // masking and request handling
    // ************************************************
    input_mask u_mask (
        .pclk     (pclk),
        .presetn  (presetn),
        .sel_pass (ready_ff),
        .usr_in   (usr_crit_in),
        .core_in  (core_crit_in)
    );

    ur_responder u_ur (
        .pclk         (pclk),
        .presetn      (presetn),
        .stage2_ready (ready_ff),
        .rx_valid     (rx_valid),
        .rx_hard      (rx_hard),
        .rx_bar_hit   (rx_bar_hit),
        .rx_tag       (rx_tag),
        .ur_valid     (ur_pulse),
        .ur_tag       (ur_tag),
        .fwd_valid    (fwd_valid),
        .fwd_tag      (fwd_tag)
    );

    // ur counter, cleared by a write to HO_URCNT_OFF; a count in the same cycle as that write loads 1
    always_comb begin
        nxt_urcnt = urcnt_ff;
        if (wr_acc && paddr == `HO_URCNT_OFF) begin
            nxt_urcnt = `HO_CNT_RST;
        end
        if (ur_pulse) begin
            nxt_urcnt = (wr_acc && paddr == `HO_URCNT_OFF) ? `HO_CNT_W'(1)
                                                           : urcnt_ff + `HO_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            urcnt_ff <= `HO_CNT_RST;
        end else begin
            urcnt_ff <= nxt_urcnt;
        end
    end

    // ************************************************
    // apb slave
    // ************************************************
    always_comb begin
        hit = (paddr == `HO_CTRL_OFF) || (paddr == `HO_CAP_OFF) ||
              (paddr == `HO_STATUS_OFF) || (paddr == `HO_URCNT_OFF);
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;
        if (setup) begin
            nxt_err   = !hit || (pwrite && paddr == `HO_STATUS_OFF);
            nxt_rdata = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `HO_CTRL_OFF: begin
                        nxt_rdata[`HO_CTRL_SWITCH] = ready_ff;
                    end
                    `HO_CAP_OFF: begin
                        nxt_rdata[`HO_CAP_REQ] = sw_req_ff;
                    end
                    `HO_STATUS_OFF: begin
                        nxt_rdata[`HO_ST_READY]  = ready_ff;
                        nxt_rdata[`HO_ST_EOS]    = eos_ff;
                        nxt_rdata[`HO_ST_LINK]   = link_ff;
                        nxt_rdata[`HO_ST_RESET]  = reset_ff;
                        nxt_rdata[`HO_ST_CREQ]   = cap_req_ff;
                        nxt_rdata[`HO_ST_CGNT]   = cap_gnt;
                        nxt_rdata[`HO_ST_CREL]   = cap_rel;
                        nxt_rdata[`HO_ST_ACCESS] = access_ff;
                        nxt_rdata[`HO_ST_INIT]   = init_done_ff;
                    end
                    `HO_URCNT_OFF: begin
                        nxt_rdata[`HO_CNT_W-1:0] = urcnt_ff;
                    end
                    default: begin
                        nxt_rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
            err_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign prdata       = rdata_ff;
    assign pready       = 1'b1;
    assign pslverr      = psel && penable && err_ff;
    assign eos_out      = eos_ff;
    assign stage2_ready = ready_ff;
    assign ur_valid     = ur_pulse;
    assign cap_req      = cap_req_ff;
    assign cfg_access   = access_ff;
    assign user_reset   = reset_ff;
    assign user_lnk_up  = link_ff;

endmodule
`default_nettype wire

// *** dv/staged_config_handoff_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "handoff_map.svh"

module staged_config_handoff_properties (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [`HO_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  eos_in,
    input wire logic                  eos_out,
    input wire logic                  stage2_ready,
    input wire logic [`HO_CRIT_W-1:0] core_crit_in,
    input wire logic                  rx_valid,
    input wire logic                  rx_hard,
    input wire handoff_pkg::tag_t     rx_tag,
    input wire logic                  ur_valid,
    input wire logic [`HO_TAG_W-1:0]  ur_tag,
    input wire logic                  fwd_valid,
    input wire logic [`HO_TAG_W-1:0]  fwd_tag,
    input wire logic                  cap_req,
    input wire logic                  cap_gnt,
    input wire logic                  cap_rel,
    input wire logic                  cfg_access,
    input wire logic                  core_reset_in,
    input wire logic                  user_reset
);
    import handoff_pkg::*;

    logic       eos_prev_ff;
    logic [1:0] rise_ff;
    logic       taken;
    logic       cap_set;

    assign taken   = rx_valid && !rx_hard;
    assign cap_set = psel && penable && pwrite && paddr == `HO_CAP_OFF && pwdata[0];

    // ****************
    // eos rise counter
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eos_prev_ff <= 1'b0;
            rise_ff     <= 2'h0;
        end else begin
            eos_prev_ff <= eos_in;
            if (eos_in && !eos_prev_ff && rise_ff != 2'h2) begin
                rise_ff <= rise_ff + 2'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    eos_follow_a: assert property (eos_out == $past(eos_in))
        else $error("eos_out lost eos_in");
    mask_hold_a: assert property (!stage2_ready |=> core_crit_in == 8'h00)
        else $error("inputs not masked");
    ur_answer_a: assert property (taken && !stage2_ready |=> ur_valid && !fwd_valid && ur_tag == $past(rx_tag))
        else $error("no UR answer");
    fwd_answer_a: assert property (taken && stage2_ready |=> fwd_valid && !ur_valid && fwd_tag == $past(rx_tag))
        else $error("no forward");
    access_gnt_a: assert property (cfg_access |-> $past(cap_req && cap_gnt && !cap_rel))
        else $error("access without grant");
    req_set_a: assert property (cap_set |=> cap_req)
        else $error("cap_req not raised");
    req_drop_a: assert property (cap_rel && !cap_set |=> !cap_req)
        else $error("cap_req kept on release");
    ready_early_a: assert property (stage2_ready |-> rise_ff == 2'h2)
        else $error("ready too early");
    ready_rise_a: assert property (eos_in && !eos_prev_ff && rise_ff == 2'h1 |=> stage2_ready)
        else $error("ready not set");
    reset_follow_a: assert property (user_reset == $past(core_reset_in))
        else $error("user_reset wrong");

    cover property (taken && !stage2_ready ##1 ur_valid);
    cover property (fwd_valid);
    cover property (cfg_access ##1 cap_rel);
    cover property ($rose(stage2_ready));
endmodule
`default_nettype wire

// *** dv/cfg_arbiter_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cfg_arbiter_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       cap_req,
    input  wire logic       stage2_ready,
    input  wire logic       rel_cmd,
    input  wire logic [3:0] gnt_dly,
    input  wire logic       solo,
    output logic            cap_gnt,
    output logic            cap_rel,
    output logic            other_access
);
    logic [3:0] wait_ff;
    logic [3:0] nxt_wait;
    logic       gnt_ff;
    logic       nxt_gnt;
    logic       rel_ff;
    logic       nxt_rel;

    always_comb begin
        nxt_wait = wait_ff;
        nxt_gnt  = gnt_ff;
        nxt_rel  = rel_ff;
        if (cap_req && !gnt_ff) begin
            if (wait_ff >= gnt_dly) begin
                nxt_gnt = 1'b1;
            end else begin
                nxt_wait = wait_ff + 4'h1;
            end
        end
        if (gnt_ff && rel_cmd && stage2_ready) begin
            nxt_rel = 1'b1;
        end
        if (!cap_req) begin
            nxt_wait = 4'h0;
            nxt_gnt  = 1'b0;
            nxt_rel  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 4'h0;
            gnt_ff  <= 1'b0;
            rel_ff  <= 1'b0;
        end else begin
            wait_ff <= nxt_wait;
            gnt_ff  <= nxt_gnt;
            rel_ff  <= nxt_rel;
        end
    end

    assign cap_gnt = gnt_ff || solo;
    assign cap_rel = rel_ff && !solo;
    assign other_access = !cap_gnt && !cap_req;
endmodule
`default_nettype wire

// *** dv/staged_config_handoff_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "handoff_map.svh"

module staged_config_handoff_tb;
    import handoff_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        eos_in, eos_out, stage2_ready, rx_valid, rx_hard, rx_bar_hit;
    crit_t       usr_crit_in;
    tag_t        rx_tag;
    logic [7:0]  core_crit_in, ur_tag, fwd_tag;
    logic        ur_valid, fwd_valid, cap_req, cap_gnt, cap_rel, cfg_access, er;
    logic        core_reset_in, link_up_in, user_reset, user_lnk_up;
    logic        rel_cmd, other_access, solo;
    logic [3:0]  gnt_dly;
    int          failures, n_tests, cyc;

    staged_config_handoff u_staged_config_handoff (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eos_in, .eos_out,
        .stage2_ready, .usr_crit_in, .core_crit_in, .rx_valid, .rx_hard, .rx_bar_hit,
        .rx_tag, .ur_valid, .ur_tag, .fwd_valid, .fwd_tag, .cap_req, .cap_gnt, .cap_rel,
        .cfg_access, .core_reset_in, .link_up_in, .user_reset, .user_lnk_up);
    cfg_arbiter_model u_cfg_arbiter_model (.pclk, .presetn, .cap_req, .stage2_ready,
        .rel_cmd, .gnt_dly, .solo, .cap_gnt, .cap_rel, .other_access);

    always #10 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            $display("mismatch t=%0t timeout", $time);
            print_verdict();
        end
    end

    task print_verdict();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task req(input logic hard, input tag_t tag, input logic exp_ur);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_hard <= hard;
        rx_bar_hit <= ~hard;
        rx_tag <= tag;
        @(posedge pclk);
        rx_valid <= 1'b0;
        @(negedge pclk);
        chk(ur_valid, exp_ur && !hard, "ur_valid");
        chk(fwd_valid, !exp_ur && !hard, "fwd_valid");
        if (!hard) chk(exp_ur ? ur_tag : fwd_tag, tag, "tag");
    endtask

    task t_reset();
        @(negedge pclk);
        chk(user_reset, 1'b1, "user_reset");
        chk(stage2_ready, 1'b0, "ready");
        @(posedge pclk);
        core_reset_in <= 1'b0;
        link_up_in <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(user_reset, 1'b0, "user_reset");
        chk(user_lnk_up, 1'b1, "link");
    endtask

    task t_stage1();
        @(posedge pclk);
        eos_in <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(eos_out, 1'b1, "eos_out");
        chk(core_crit_in, 8'h00, "mask");
        apb(1'b1, `HO_CTRL_OFF, 32'h1);
        chk(stage2_ready, 1'b0, "ready");
        req(1'b0, 8'h11, 1'b1);
        req(1'b0, 8'h12, 1'b1);
        req(1'b1, 8'h13, 1'b1);
        apb(1'b0, `HO_URCNT_OFF, 32'h0);
        chk(rd, 32'h2, "urcnt");
        apb(1'b0, 12'h010, 32'h0);
        chk(er, 1'b1, "unmapped");
        @(posedge pclk);
        eos_in <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk(eos_out, 1'b0, "eos_out");
    endtask

    task t_stage2();
        @(posedge pclk);
        eos_in <= 1'b1;
        @(negedge pclk);
        chk(stage2_ready, 1'b0, "ready");
        @(negedge pclk);
        chk(stage2_ready, 1'b1, "ready");
        @(negedge pclk);
        chk(core_crit_in, 8'ha5, "pass");
        req(1'b0, 8'h21, 1'b0);
    endtask

    task t_root();
        apb(1'b1, `HO_CTRL_OFF, 32'h0);
        chk(stage2_ready, 1'b0, "ready");
        req(1'b0, 8'h31, 1'b1);
        chk(core_crit_in, 8'h00, "mask");
        apb(1'b0, `HO_URCNT_OFF, 32'h0);
        chk(rd, 32'h3, "urcnt");
        apb(1'b1, `HO_CTRL_OFF, 32'h1);
        chk(stage2_ready, 1'b1, "ready");
    endtask

    task t_arb();
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            gnt_dly <= (i == 0) ? 4'h5 : 4'h0;
            apb(1'b1, `HO_CAP_OFF, 32'h1);
            chk(cap_req, 1'b1, "cap_req");
            while (cfg_access !== 1'b1) @(negedge pclk);
            chk(cap_gnt, 1'b1, "gnt");
            chk(other_access, 1'b0, "other");
            @(posedge pclk);
            rel_cmd <= 1'b1;
            while (cap_req !== 1'b0) @(negedge pclk);
            chk(cfg_access, 1'b0, "access");
            @(posedge pclk);
            rel_cmd <= 1'b0;
        end
    endtask

    task t_regs();
        logic [31:0] exp;
        exp = 32'h0000_0000;
        exp[`HO_ST_READY] = 1'b1;
        exp[`HO_ST_EOS] = 1'b1;
        exp[`HO_ST_LINK] = 1'b1;
        exp[`HO_ST_INIT] = 1'b1;
        apb(1'b0, `HO_STATUS_OFF, 32'h0);
        chk(rd, exp, "status");
        chk(pready, 1'b1, "pready");
        apb(1'b0, `HO_CTRL_OFF, 32'h0);
        chk(rd, 32'h1, "ctrl");
        apb(1'b0, `HO_CAP_OFF, 32'h0);
        chk(rd, 32'h0, "cap");
        apb(1'b1, `HO_STATUS_OFF, 32'hffff_ffff);
        chk(er, 1'b1, "status write");
        chk(stage2_ready, 1'b1, "ready");
        apb(1'b1, `HO_URCNT_OFF, 32'h0);
        apb(1'b0, `HO_URCNT_OFF, 32'h0);
        chk(rd, 32'h0, "urcnt clear");
    endtask

    task t_solo();
        @(posedge pclk);
        solo <= 1'b1;
        apb(1'b1, `HO_CAP_OFF, 32'h1);
        @(negedge pclk);
        chk(cfg_access, 1'b1, "solo access");
        repeat (4) @(negedge pclk);
        chk(cap_req, 1'b1, "solo hold");
        apb(1'b1, `HO_CAP_OFF, 32'h0);
        chk(cap_req, 1'b0, "solo drop");
        @(negedge pclk);
        chk(cfg_access, 1'b0, "solo access");
        @(posedge pclk);
        solo <= 1'b0;
    endtask

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; eos_in = 0; usr_crit_in = 8'ha5; rx_valid = 0; rx_hard = 0;
        rx_bar_hit = 0; rx_tag = 8'h00; core_reset_in = 1; link_up_in = 0;
        rel_cmd = 0; gnt_dly = 4'h0; failures = 0; n_tests = 0; cyc = 0; solo = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_stage1();
        t_stage2();
        t_root();
        t_arb();
        t_regs();
        t_solo();
        print_verdict();
    end
endmodule

bind staged_config_handoff staged_config_handoff_properties u_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .eos_in, .eos_out, .stage2_ready,
    .core_crit_in, .rx_valid, .rx_hard, .rx_tag, .ur_valid, .ur_tag, .fwd_valid,
    .fwd_tag, .cap_req, .cap_gnt, .cap_rel, .cfg_access, .core_reset_in, .user_reset);
`default_nettype wire
